// ### design/pll_limp_home_stop_exit_ctrl.sv
// Purpose: loop control/status registers, limp-home and stop exit control
// Assumes: counter clock tick arrives as one-cycle pulse; crystal and lock
//          status are asynchronous levels and are synchronised here
// Notes: all state lives in one packed struct
//        the supply synchroniser resets high so the loop-on reset value stands
//        limp-home exit with delay keeps the part stopped until the first check
//
// Behaviour
// - no limp, monitor off: exit after 4096 ticks
// - no limp, monitor on: stop causes monitor reset
// - limp, delay: 4096 ticks then check monitor
// - pseudo-stop limp exit runs limp, then crystal
// - pseudo-stop no limp: crystal after 4096 ticks, 16 ticks without exit delay
// - reset with loop supply enters limp-home
// - multiplier sets bus gain of value plus one
// - system clock runs at twice bus clock
// - divider divides reference; writes blocked on loop
// - test register always reads zero
// - lock change flag: set on change, clear-one
// - lock bit read-only, zero in limp-home
// - limp change flag set on enter/leave
// - limp status set while reference lost
// - power and no-limp reset follow loop supply
// - lock irq enable gated, zero without supply
// - power not cleared on loop; forced in limp
// - auto bandwidth makes acquisition bit read-only
// - acquisition bit meaning per bandwidth mode
// - pseudo-stop keeps oscillator running in stop
// - no-limp: loss resets; write-once in normal
`timescale 1ns/1ps
module pll_limp_home_stop_exit_ctrl
    import loop_ctrl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // system status inputs
    input wire logic loopSupply,
    input wire logic specialMode,
    input wire logic busClockFromLoop,
    input wire logic clockMonitorEnable,
    input wire logic stopExitDelay,
    input wire logic counterClockTick,
    input wire logic stopRequest,
    input wire logic wakeRequest,
    input wire logic crystalPresent,
    input wire logic loopInLock,
    input wire logic loopNearTarget,
    // control outputs
    output logic [7:0] loopMultiplier,
    output logic [7:0] referenceDivider,
    output logic loopPowerOut,
    output logic bandwidthLow,
    output logic oscillatorRun,
    output logic stopActive,
    output logic limpClockSelect,
    output logic monitorReset,
    output logic systemClockDouble,
    output logic lockIrq,
    output logic limpIrq
);
    typedef struct packed {
        logic [7:0] mult;
        logic [7:0] refDiv;
        logic lockChg;
        logic lockSt;
        logic limpChg;
        logic limpSt;
        logic lock_change_irq_en;
        logic pwr;
        logic autoBw;
        logic acquisition_select;
        logic pStop;
        logic limpIe;
        logic noLimp;
        logic noLimpWritten;
        logic resetLimpDone;
        stopState_t st;
        logic pseudo;
        logic exitHold;
        logic [CNT_W-1:0] cnt;
        logic [1:0] xtalSync;
        logic [1:0] lockSync;
        logic [1:0] nearSync;
        logic [1:0] supplySync;
        logic [7:0] rdData;
        logic pwrOut;
        logic bwLow;
        logic oscRun;
        logic stopAct;
        logic limpSel;
        logic monRst;
        logic lockIrq;
        logic limpIrq;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic xtalOk;
    logic lockNow;
    logic nearNow;
    logic supplyOk;
    logic wrFlags;
    logic wrCtrl;
    logic limpEnter;
    logic limpLeave;
    logic [7:0] flagsView;
    logic [7:0] ctrlView;

    // ----------------------------------------------------------
    // combinational next-state
    // ----------------------------------------------------------
    always_comb begin
        next_cur = cur;
        xtalOk = cur.xtalSync[1];
        lockNow = cur.lockSync[1];
        nearNow = cur.nearSync[1];
        supplyOk = cur.supplySync[1];
        limpEnter = 1'b0;
        limpLeave = 1'b0;
        // two-stage synchronisers for external levels
        next_cur.xtalSync = {cur.xtalSync[0], crystalPresent};
        next_cur.lockSync = {cur.lockSync[0], loopInLock};
        next_cur.nearSync = {cur.nearSync[0], loopNearTarget};
        next_cur.supplySync = {cur.supplySync[0], loopSupply};
        // register strobes decoded once for the flag and control writes
        wrFlags = regWrite && (regAddr == OFS_FLAGS);
        wrCtrl = regWrite && (regAddr == OFS_CTRL);
        // monitor reset defaults low each cycle and stays high only while a stop request or a lost crystal re-asserts it
        next_cur.monRst = 1'b0;

        // multiplier and divider writes blocked while loop drives bus
        if (regWrite && regAddr == OFS_MULT && !busClockFromLoop) begin
            next_cur.mult = regWrData;
        end
        if (regWrite && regAddr == OFS_REFDIV && !busClockFromLoop) begin
            next_cur.refDiv = regWrData;
        end

        // control register writes
        if (wrCtrl) begin
            next_cur.lock_change_irq_en = regWrData[BIT_LOCK_CHANGE_IRQ_EN];
            if (regWrData[BIT_PWR] || !busClockFromLoop) begin
                next_cur.pwr = regWrData[BIT_PWR];
            end
            next_cur.autoBw = regWrData[BIT_AUTO];
            if (!cur.autoBw) begin
                next_cur.acquisition_select = regWrData[BIT_ACQ];
            end
            next_cur.pStop = regWrData[BIT_PSTOP];
            next_cur.limpIe = regWrData[BIT_LIMPIE];
            if (specialMode || !cur.noLimpWritten) begin
                next_cur.noLimp = regWrData[BIT_NOLIMP];
                next_cur.noLimpWritten = 1'b1;
            end
        end
        // hardware bandwidth choice when automatic
        if (next_cur.autoBw) begin
            next_cur.acquisition_select = nearNow;
        end

        // stop and limp-home sequencing
        case (cur.st)
            ST_RUN: begin
                // first cycle out of reset: limp-home if the loop supply is up
                if (!cur.resetLimpDone) begin
                    next_cur.resetLimpDone = 1'b1;
                    if (supplyOk) begin
                        limpEnter = 1'b1;
                        next_cur.st = ST_LIMPCHECK;
                        next_cur.cnt = '0;
                    end
                end else if (cur.noLimp && clockMonitorEnable && !xtalOk) begin
                    next_cur.monRst = 1'b1;
                end else if (stopRequest) begin
                    if (cur.noLimp && clockMonitorEnable) begin
                        next_cur.monRst = 1'b1;
                    end else begin
                        next_cur.st = ST_STOPPED;
                        next_cur.pseudo = cur.pStop;
                    end
                end else if (!cur.noLimp && !xtalOk && supplyOk) begin
                    limpEnter = 1'b1;
                    next_cur.st = ST_LIMPCHECK;
                    next_cur.cnt = '0;
                end
            end
            ST_STOPPED: begin
                // wake: limp-home exit or a counted crystal exit
                if (wakeRequest) begin
                    next_cur.cnt = '0;
                    if (!cur.noLimp) begin
                        // exit runs on the limp-home clock
                        limpEnter = 1'b1;
                        next_cur.st = ST_LIMPCHECK;
                        // with delay the part stays stopped for one full count
                        next_cur.exitHold = stopExitDelay;
                        if (!stopExitDelay) begin
                            // fast recovery: first monitor check on the next tick
                            next_cur.cnt = EXIT_LAST;
                        end
                    end else begin
                        next_cur.st = ST_DELAY;
                        if (!stopExitDelay && cur.pseudo) begin
                            next_cur.cnt = EXIT_LAST - FAST_LAST;
                        end
                    end
                end
            end
            ST_DELAY: begin
                // counter-clock delay before crystal resumes
                if (counterClockTick) begin
                    next_cur.cnt = cur.cnt + 1'b1;
                    if (cur.cnt == EXIT_LAST) begin
                        next_cur.st = ST_RUN;
                    end
                end
            end
            ST_LIMPCHECK: begin
                // check monitor at each 4096-tick boundary
                if (counterClockTick) begin
                    next_cur.cnt = cur.cnt + 1'b1;
                    if (cur.cnt == EXIT_LAST) begin
                        next_cur.cnt = '0;
                        // stop ends at the first check whatever the crystal shows
                        next_cur.exitHold = 1'b0;
                        if (xtalOk) begin
                            next_cur.st = ST_RUN;
                        end
                    end
                end
            end
            default: begin
                next_cur.st = ST_RUN;
            end
        endcase

        // leaving the limp-home check means the crystal is back
        if (cur.st == ST_LIMPCHECK && next_cur.st == ST_RUN) begin
            limpLeave = 1'b1;
        end

        // limp-home status and change flag; set beats clear
        next_cur.limpSt = (next_cur.st == ST_LIMPCHECK);
        if (wrFlags && regWrData[BIT_LIMPCHG]) begin
            next_cur.limpChg = 1'b0;
        end
        if (limpEnter || limpLeave) begin
            next_cur.limpChg = 1'b1;
        end

        // lock status and lock change flag
        // a lock change beside a clearing write still sets the flag
        next_cur.lockSt = lockNow && cur.pwr && !next_cur.limpSt;
        if (wrFlags && regWrData[BIT_LOCKCHG]) begin
            next_cur.lockChg = 1'b0;
        end
        if (next_cur.lockSt != cur.lockSt) begin
            next_cur.lockChg = 1'b1;
        end
        if (next_cur.limpSt) begin
            next_cur.lockChg = 1'b0;
        end

        // loop supply absent forces control bits
        // forcing follows the synchronised supply, two cycles behind the pin
        if (!supplyOk) begin
            next_cur.pwr = 1'b0;
            next_cur.noLimp = 1'b1;
            next_cur.lock_change_irq_en = 1'b0;
            next_cur.limpIe = 1'b0;
        end

        // registered outputs
        next_cur.pwrOut = next_cur.pwr || next_cur.limpSt;
        next_cur.bwLow = next_cur.acquisition_select;
        // stopped, counting out a crystal exit, or held through the limp delay
        next_cur.stopAct = (next_cur.st == ST_STOPPED) || (next_cur.st == ST_DELAY)
                           || next_cur.exitHold;
        next_cur.oscRun = !(next_cur.st == ST_STOPPED) || next_cur.pseudo;
        next_cur.limpSel = next_cur.limpSt;
        next_cur.lockIrq = next_cur.lockChg && next_cur.lock_change_irq_en;
        next_cur.limpIrq = next_cur.limpChg && next_cur.limpIe;

        // read data, one cycle after the strobe
        flagsView = {cur.lockChg, cur.lockSt, 4'h0, cur.limpChg, cur.limpSt};
        ctrlView = {cur.lock_change_irq_en, cur.pwr, cur.autoBw, cur.acquisition_select, 1'b0,
                    cur.pStop, cur.limpIe, cur.noLimp};
        next_cur.rdData = 8'h00;
        if (regRead) begin
            case (regAddr)
                OFS_MULT: next_cur.rdData = cur.mult;
                OFS_REFDIV: next_cur.rdData = cur.refDiv;
                OFS_TEST: next_cur.rdData = 8'h00;
                OFS_FLAGS: next_cur.rdData = flagsView;
                OFS_CTRL: next_cur.rdData = ctrlView;
                default: next_cur.rdData = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
            cur.mult <= RST_MULT;
            cur.refDiv <= RST_REFDIV;
            cur.pwr <= RST_CTRL_HI[BIT_PWR];
            cur.autoBw <= RST_CTRL_HI[BIT_AUTO];
            cur.noLimp <= RST_CTRL_HI[BIT_NOLIMP];
            // supply taken as present until the synchroniser sees it; this keeps
            // the loop-on reset values and lets the reset limp-home entry happen
            cur.supplySync <= {2{RST_CTRL_HI[BIT_PWR]}};
            cur.st <= ST_RUN;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------
    // outputs straight from flip-flops
    // ----------------------------------------------------------
    assign regRdData = cur.rdData;
    assign loopMultiplier = cur.mult;
    assign referenceDivider = cur.refDiv;
    assign loopPowerOut = cur.pwrOut;
    assign bandwidthLow = cur.bwLow;
    assign oscillatorRun = cur.oscRun;
    assign stopActive = cur.stopAct;
    assign limpClockSelect = cur.limpSel;
    assign monitorReset = cur.monRst;
    assign systemClockDouble = cur.pwrOut;
    assign lockIrq = cur.lockIrq;
    assign limpIrq = cur.limpIrq;
endmodule

// ### design/loop_ctrl_pkg.sv
// Purpose: constants shared by the loop control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: bit positions follow the flag and control register layouts
package loop_ctrl_pkg;
    // ----------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------
    localparam logic [7:0] OFS_MULT = 8'h38;
    localparam logic [7:0] OFS_REFDIV = 8'h39;
    localparam logic [7:0] OFS_TEST = 8'h3A;
    localparam logic [7:0] OFS_FLAGS = 8'h3B;
    localparam logic [7:0] OFS_CTRL = 8'h3C;
    // ----------------------------------------------------------
    // flag register bit positions
    // ----------------------------------------------------------
    localparam int BIT_LOCKCHG = 7;
    localparam int BIT_LOCK = 6;
    localparam int BIT_LIMPCHG = 1;
    localparam int BIT_LIMP = 0;
    // ----------------------------------------------------------
    // control register bit positions
    // ----------------------------------------------------------
    localparam int BIT_LOCK_CHANGE_IRQ_EN = 7;
    localparam int BIT_PWR = 6;
    localparam int BIT_AUTO = 5;
    localparam int BIT_ACQ = 4;
    localparam int BIT_PSTOP = 2;
    localparam int BIT_LIMPIE = 1;
    localparam int BIT_NOLIMP = 0;
    // ----------------------------------------------------------
    // reset values
    // ----------------------------------------------------------
    localparam logic [7:0] RST_MULT = 8'h00;
    localparam logic [7:0] RST_REFDIV = 8'h00;
    localparam logic [7:0] RST_CTRL_HI = 8'h60; // power on, auto on
    localparam logic [7:0] RST_CTRL_LO = 8'h21; // power off, no limp-home
    // ----------------------------------------------------------
    // stop exit timing in counter clock cycles
    // ----------------------------------------------------------
    localparam int EXIT_CYCLES = 4096;
    localparam int FAST_CYCLES = 16;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] EXIT_LAST = CNT_W'(EXIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_CYCLES - 1);
    // ----------------------------------------------------------
    // stop sequencer states
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,
        ST_STOPPED,
        ST_DELAY,
        ST_LIMPCHECK
    } stopState_t;
endpackage

// ### verif/loop_ctrl_props.sv
// Purpose: port-level checks of the loop control block
// Assumes: register writes land on the edge that takes them
// Notes: bound to the block from tb
`timescale 1ns/1ps
module loop_ctrl_props
    import loop_ctrl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic busClockFromLoop,
    // watched outputs
    input wire logic [7:0] loopMultiplier,
    input wire logic [7:0] referenceDivider,
    input wire logic loopPowerOut,
    input wire logic systemClockDouble,
    input wire logic lockIrq,
    input wire logic limpIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------------------------
    // register and output relations
    // ----------------------------------------------------------
    test_zero_a: assert property (regRead && regAddr == OFS_TEST |=> regRdData == 8'h00)
        else $error("test register read not zero");
    mult_load_a: assert property (
        regWrite && regAddr == OFS_MULT && !busClockFromLoop
        |=> loopMultiplier == $past(regWrData))
        else $error("multiplier not loaded");
    mult_hold_a: assert property (
        regWrite && regAddr == OFS_MULT && busClockFromLoop |=> $stable(loopMultiplier))
        else $error("multiplier written while loop drives bus");
    div_load_a: assert property (
        regWrite && regAddr == OFS_REFDIV && !busClockFromLoop
        |=> referenceDivider == $past(regWrData))
        else $error("divider not loaded");
    div_hold_a: assert property (
        regWrite && regAddr == OFS_REFDIV && busClockFromLoop |=> $stable(referenceDivider))
        else $error("divider written while loop drives bus");
    clk_double_a: assert property (systemClockDouble == loopPowerOut)
        else $error("double clock marker differs from loop power");
    pwr_keep_a: assert property (regWrite && regAddr == OFS_CTRL && busClockFromLoop
        && !regWrData[BIT_PWR] && loopPowerOut |=> loopPowerOut)
        else $error("loop power cleared while loop drives bus");
    lock_irq_off_a: assert property (
        regWrite && regAddr == OFS_CTRL && !regWrData[BIT_LOCK_CHANGE_IRQ_EN] |-> ##[1:2] !lockIrq)
        else $error("lock request with enable clear");
    limp_irq_off_a: assert property (
        regWrite && regAddr == OFS_CTRL && !regWrData[BIT_LIMPIE] |-> ##[1:2] !limpIrq)
        else $error("limp request with enable clear");
endmodule

// ### verif/tb.sv
// Purpose: register and stop exit scenarios for the loop control block
// Assumes: read data sampled in the cycle after the read strobe
// Notes: counter clock ticks come every second cycle
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import loop_ctrl_pkg::*;
    logic ref_clk = 0, rst_b = 0, regWrite = 0, regRead = 0, specialMode = 0;
    logic loopSupply = 1, busClockFromLoop = 0, clockMonitorEnable = 0, stopExitDelay = 0;
    logic counterClockTick = 0, stopRequest = 0, wakeRequest = 0, crystalPresent = 1;
    logic loopInLock = 0, loopNearTarget = 0, loopPowerOut, bandwidthLow, oscillatorRun;
    logic stopActive, limpClockSelect, monitorReset, lockIrq, limpIrq, ok;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, loopMultiplier, referenceDivider;
    int n_errors = 0, n_tests = 0;
    pll_limp_home_stop_exit_ctrl uut (.ref_clk, .rst_b, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .loopSupply, .specialMode, .busClockFromLoop, .clockMonitorEnable,
        .stopExitDelay, .counterClockTick, .stopRequest, .wakeRequest, .crystalPresent,
        .loopInLock, .loopNearTarget, .loopMultiplier, .referenceDivider, .loopPowerOut,
        .bandwidthLow, .oscillatorRun, .stopActive, .limpClockSelect, .monitorReset,
        .systemClockDouble(), .lockIrq, .limpIrq);
    // clock
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        `CHK(regRdData, e)
    endtask
    task automatic req(input logic wake);
        @(posedge ref_clk);
        stopRequest <= !wake;
        wakeRequest <= wake;
        @(posedge ref_clk);
        stopRequest <= 1'b0;
        wakeRequest <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            counterClockTick <= 1'b1;
            @(posedge ref_clk);
            counterClockTick <= 1'b0;
        end
    endtask
    // stop, wake, then still stopped one tick short of n and running after it
    task automatic exit_chk(input int n, input logic expLimp, input logic ps);
        req(1'b0);
        repeat (3) @(negedge ref_clk);
        `CHK(oscillatorRun, ps)
        req(1'b1);
        ticks(n - 1);
        @(negedge ref_clk);
        `CHK(stopActive, 1'b1)
        ticks(1);
        repeat (4) @(negedge ref_clk);
        `CHK(stopActive, 1'b0)
        `CHK(limpClockSelect, expLimp)
    endtask
    // reset, then count the part out of the limp-home mode that reset enters
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(limpClockSelect, 1'b1)
        ticks(EXIT_CYCLES);
        repeat (4) @(negedge ref_clk);
        `CHK(limpClockSelect, 1'b0)
        wr(OFS_FLAGS, 8'h82);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    initial begin
        do_reset();
        rdchk(OFS_CTRL, RST_CTRL_HI);
        rdchk(OFS_TEST, 8'h00);
        rdchk(8'h3D, 8'h00);
        wr(OFS_MULT, 8'h5A);
        wr(OFS_REFDIV, 8'hA5);
        busClockFromLoop <= 1'b1;
        wr(OFS_MULT, 8'h11);
        wr(OFS_REFDIV, 8'h22);
        rdchk(OFS_MULT, 8'h5A);
        rdchk(OFS_REFDIV, 8'hA5);
        wr(OFS_CTRL, 8'h20);
        rdchk(OFS_CTRL, 8'h60);
        @(posedge ref_clk);
        busClockFromLoop <= 1'b0;
        wr(OFS_CTRL, 8'h04);
        wr(OFS_CTRL, 8'h14);
        rdchk(OFS_CTRL, 8'h14);
        `CHK(bandwidthLow, 1'b1)
        wr(OFS_CTRL, 8'h34);
        rdchk(OFS_CTRL, 8'h24);
        wr(OFS_CTRL, 8'hE2);
        loopInLock <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rdchk(OFS_FLAGS, 8'hC0);
        `CHK(lockIrq, 1'b1)
        wr(OFS_FLAGS, 8'h80);
        rdchk(OFS_FLAGS, 8'h40);
        @(posedge ref_clk);
        crystalPresent <= 1'b0;
        clockMonitorEnable <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rdchk(OFS_FLAGS, 8'h03);
        `CHK(limpIrq, 1'b1)
        wr(OFS_CTRL, 8'hA2);
        rdchk(OFS_CTRL, 8'hA2);
        `CHK(loopPowerOut, 1'b1)
        @(posedge ref_clk);
        loopSupply <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rdchk(OFS_CTRL, 8'h21);
        @(posedge ref_clk);
        loopSupply <= 1'b1;
        crystalPresent <= 1'b1;
        clockMonitorEnable <= 1'b0;
        stopExitDelay <= 1'b1;
        do_reset();
        wr(OFS_CTRL, 8'h61);
        exit_chk(4096, 1'b0, 1'b0);
        wr(OFS_CTRL, 8'h60);
        rdchk(OFS_CTRL, 8'h61);
        wr(OFS_CTRL, 8'h65);
        exit_chk(4096, 1'b0, 1'b1);
        @(posedge ref_clk);
        stopExitDelay <= 1'b0;
        exit_chk(16, 1'b0, 1'b1);
        @(posedge ref_clk);
        clockMonitorEnable <= 1'b1;
        req(1'b0);
        ok = 1'b0;
        repeat (4) begin
            @(negedge ref_clk);
            ok |= monitorReset;
        end
        `CHK(ok, 1'b1)
        @(posedge ref_clk);
        clockMonitorEnable <= 1'b0;
        stopExitDelay <= 1'b1;
        do_reset();
        exit_chk(4096, 1'b0, 1'b0);
        wr(OFS_CTRL, 8'h64);
        crystalPresent <= 1'b0;
        exit_chk(4096, 1'b1, 1'b1);
        @(posedge ref_clk);
        crystalPresent <= 1'b1;
        ticks(4096);
        repeat (4) @(negedge ref_clk);
        `CHK(limpClockSelect, 1'b0)
        end_of_test();
    end
    // run limit
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end
endmodule
bind pll_limp_home_stop_exit_ctrl loop_ctrl_props chk (.ref_clk, .rst_b, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .busClockFromLoop, .loopMultiplier, .referenceDivider,
    .loopPowerOut, .systemClockDouble, .lockIrq, .limpIrq);
